// ==== ccrg_map.svh ====
// constants for the control cell reply generator
`ifndef CCRG_MAP_SVH
`define CCRG_MAP_SVH
`define CMD_INTR        8'h00
`define CMD_UB_READ     8'h03
`define CMD_STATUS      8'h05
`define CMD_ADDR_CHG    8'h06
`define CTRL_ADDR_RST   8'h1F
`define REPLY_VCI_MID   8'h02
`define ZERO_BYTE       8'h00
`define ZERO_NIB        4'h0
`define BYTE_VCI_MID    6'h02
`define BYTE_CMD        6'h05
`define BYTE_DATA1      6'h06
`define BYTE_DATA2      6'h07
`define LAST_NIB        7'h69
`define NIB_ONE         7'h01
`define INT_FLAG_BIT    7
`endif

// ==== ccrg_pkg.sv ====
// types for the control cell reply generator
package ccrg_pkg;
    typedef enum logic [1:0] {
        IDLE,
        READ_WAIT,
        FRAME,
        SEND
    } state_t;
endpackage

// ==== cell_sink.sv ====
// cell sink model standing in for the cell switch receive port
`timescale 1ns/10ps
`default_nettype none
module cell_sink (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       cell_frm,
    input  wire logic       cell_valid,
    input  wire logic [3:0] cell_nib,
    output logic      [7:0] cell_byte [0:52],
    output int              cell_count
);
    int nib_idx; // nibble position within the cell
    // no flow control on this path: every nibble up to the 106th after a frame marker is taken as it comes
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            nib_idx    <= 0;
            cell_count <= 0;
        end
        else if (cell_frm)
            nib_idx <= 0;
        else if (cell_valid && nib_idx < 106)
        begin
            // high nibble of each byte arrives first
            if (nib_idx[0] == 1'b0)
                cell_byte[nib_idx / 2][7:4] <= cell_nib;
            else
                cell_byte[nib_idx / 2][3:0] <= cell_nib;
            if (nib_idx == 105)
                cell_count <= cell_count + 1;
            nib_idx <= nib_idx + 1;
        end
    end
endmodule
`default_nettype wire

// ==== control_cell_reply_generator.sv ====
// reply cell builder and control cell address holder
`timescale 1ns/10ps
`default_nettype none
`include "ccrg_map.svh"
module control_cell_reply_generator #(
    parameter logic [7:0] REVISION = 8'h01 // arbitrary value
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_byte,
    input  wire logic [7:0] first_argument_byte,
    input  wire logic [7:0] second_argument_byte,
    input  wire logic       rd_done,
    input  wire logic [7:0] rd_data,
    input  wire logic       phy_interrupt_in,
    input  wire logic [7:0] hdr_vci_low,
    output logic            cmd_ready,
    output logic            rd_req,
    output logic      [7:0] rd_addr,
    output logic      [7:0] ctrl_addr,
    output logic            ctrl_match,
    output logic            cell_frm,
    output logic            cell_valid,
    output logic      [3:0] cell_nib
);
    ccrg_pkg::state_t state;      // sequencer state
    ccrg_pkg::state_t next_state; // next sequencer state
    logic       int_prev;         // last interrupt level
    logic       int_pend;         // interrupt cell owed
    logic [7:0] cmd_b;            // reply byte 5
    logic [7:0] d1_b;             // reply byte 6
    logic [7:0] d2_b;             // reply byte 7
    logic [6:0] nib_cnt;          // next nibble to send
    logic [6:0] out_idx;          // nibble now on cell_nib

    // decode of the accepted command
    wire        take_cmd  = cmd_valid && cmd_ready;
    wire        is_read   = take_cmd && (cmd_byte == `CMD_UB_READ);
    wire        is_stat   = take_cmd && (cmd_byte == `CMD_STATUS);
    wire        is_chg    = take_cmd && (cmd_byte == `CMD_ADDR_CHG);
    wire        int_rise  = phy_interrupt_in && !int_prev;
    // interrupt cell only when no command claims the idle slot
    wire        take_int  = (state == ccrg_pkg::IDLE) && int_pend
                            && !take_cmd;
    // status byte: interrupt level now, low bits zero
    wire [7:0]  stat_b    = {phy_interrupt_in, 7'h00};
    // byte and nibble select for the outgoing cell
    wire [5:0]  byte_idx  = nib_cnt[6:1];
    wire [7:0]  cur_byte  =
        (byte_idx == `BYTE_VCI_MID) ? `REPLY_VCI_MID :
        (byte_idx == `BYTE_CMD)     ? cmd_b :
        (byte_idx == `BYTE_DATA1)   ? d1_b :
        (byte_idx == `BYTE_DATA2)   ? d2_b :
        `ZERO_BYTE;
    wire [3:0]  cur_nib   = nib_cnt[0] ? cur_byte[3:0] : cur_byte[7:4];
    wire        last_nib  = (nib_cnt == `LAST_NIB);

    // sequencer next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            // an address change never leaves idle, so no cell follows it
            ccrg_pkg::IDLE:
                if (is_read)
                    next_state = ccrg_pkg::READ_WAIT;
                else if (is_stat || take_int)
                    next_state = ccrg_pkg::FRAME;
            ccrg_pkg::READ_WAIT:
                if (rd_done)
                    next_state = ccrg_pkg::FRAME;
            ccrg_pkg::FRAME:
                next_state = ccrg_pkg::SEND;
            ccrg_pkg::SEND:
                if (last_nib)
                    next_state = ccrg_pkg::IDLE;
        endcase
    end

    // state register and command acceptance
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state     <= ccrg_pkg::IDLE;
            cmd_ready <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            // ready is registered, so a command taken the cycle an interrupt turns pending wins the tie
            cmd_ready <= (next_state == ccrg_pkg::IDLE) && !int_pend;
        end
    end

    // interrupt edge catch; a new edge beats the clear
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            int_prev <= 1'b0;
            int_pend <= 1'b0;
        end
        else
        begin
            int_prev <= phy_interrupt_in;
            if (int_rise)
                int_pend <= 1'b1;
            else if (take_int)
                int_pend <= 1'b0;
        end
    end

    // control cell address, only one address is ever filtered
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_addr  <= `CTRL_ADDR_RST;
            ctrl_match <= 1'b0;
        end
        else
        begin
            if (is_chg)
                ctrl_addr <= first_argument_byte;
            ctrl_match <= (hdr_vci_low == ctrl_addr);
        end
    end

    // peripheral read request, held until the data returns
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_req  <= 1'b0;
            rd_addr <= `ZERO_BYTE;
        end
        else if (is_read)
        begin
            rd_req  <= 1'b1;
            rd_addr <= first_argument_byte;
        end
        else if (rd_done)
            rd_req  <= 1'b0;
    end

    // reply content captured at build time
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cmd_b <= `ZERO_BYTE;
            d1_b  <= `ZERO_BYTE;
            d2_b  <= `ZERO_BYTE;
        end
        else if (is_read)
        begin
            cmd_b <= cmd_byte;
            d1_b  <= first_argument_byte;
        end
        else if (state == ccrg_pkg::READ_WAIT && rd_done)
            d2_b  <= rd_data;
        else if (is_stat || take_int)
        begin
            cmd_b <= is_stat ? cmd_byte : `CMD_INTR;
            d1_b  <= stat_b;
            d2_b  <= REVISION;
        end
    end

    // cell output: frame marker one cycle ahead of nibble 0
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cell_frm   <= 1'b0;
            cell_valid <= 1'b0;
            cell_nib   <= `ZERO_NIB;
            nib_cnt    <= 7'h00;
            out_idx    <= 7'h00;
        end
        else
        begin
            cell_frm   <= (state == ccrg_pkg::FRAME);
            cell_valid <= (state == ccrg_pkg::SEND);
            cell_nib   <= (state == ccrg_pkg::SEND) ? cur_nib : `ZERO_NIB;
            out_idx    <= nib_cnt;
            // counter runs only while nibbles leave
            if (state == ccrg_pkg::SEND)
                nib_cnt <= last_nib ? 7'h00 : nib_cnt + `NIB_ONE;
        end
    end

    // checks on the reply stream and the command effects
    hdr_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        cell_valid && out_idx < 7'h04 |-> cell_nib == 4'h0)
        else $error("header nibble not zero");
    vci_mid_a: assert property (@(posedge clk) disable iff (sys_rst)
        cell_valid && out_idx == 7'h05 |-> cell_nib == 4'h2)
        else $error("vci nibble wrong");
    pti_clp_a: assert property (@(posedge clk) disable iff (sys_rst)
        cell_valid && out_idx == 7'h07 |-> cell_nib == 4'h0)
        else $error("pti or clp not zero");
    hec_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        cell_valid && (out_idx == 7'h08 || out_idx == 7'h09)
        |-> cell_nib == 4'h0)
        else $error("hec not zero");
    pad_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        cell_valid && out_idx >= 7'h10 |-> cell_nib == 4'h0)
        else $error("padding not zero");
    cmd_echo_a: assert property (@(posedge clk) disable iff (sys_rst)
        cell_valid && out_idx == 7'h0A |-> cell_nib == cmd_b[7:4])
        else $error("command echo wrong");
    addr_chg_a: assert property (@(posedge clk) disable iff (sys_rst)
        is_chg |=> ctrl_addr == $past(first_argument_byte))
        else $error("address not replaced");
    no_reply_a: assert property (@(posedge clk) disable iff (sys_rst)
        is_chg |=> !cell_frm [*3])
        else $error("reply after address change");
    filter_a: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 ctrl_match == ($past(hdr_vci_low) == $past(ctrl_addr)))
        else $error("filter match wrong");
    read_req_a: assert property (@(posedge clk) disable iff (sys_rst)
        is_read |=> rd_req && rd_addr == $past(first_argument_byte))
        else $error("read not requested");
    status_a: assert property (@(posedge clk) disable iff (sys_rst)
        is_stat |-> ##2 cell_frm ##1 cell_valid [*8])
        else $error("status cell missing");
    int_cell_a: assert property (@(posedge clk) disable iff (sys_rst)
        take_int |=> cmd_b == 8'h00 && d2_b == REVISION ##1 cell_frm)
        else $error("interrupt cell wrong");
    stat_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
        is_stat |=> d1_b == {$past(phy_interrupt_in), 7'h00})
        else $error("status bit wrong");
    read_data_a: assert property (@(posedge clk) disable iff (sys_rst)
        state == ccrg_pkg::READ_WAIT && rd_done |=> d2_b == $past(rd_data))
        else $error("read data wrong");
    cov_read_c: cover property (@(posedge clk) is_read ##[1:50] cell_frm);
    cov_stat_c: cover property (@(posedge clk) is_stat ##2 cell_frm);
    cov_int_c: cover property (@(posedge clk) take_int ##2 cell_frm);
    cov_chg_c: cover property (@(posedge clk) is_chg ##1 ctrl_match);
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the control cell reply generator
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [7:0] REV = 8'h5A; // arbitrary revision value
    logic clk, sys_rst, cmd_valid, rd_done, phy_interrupt_in;
    logic [7:0] cmd_byte, first_argument_byte, second_argument_byte;
    logic [7:0] rd_data, hdr_vci_low, rd_addr, ctrl_addr;
    logic cmd_ready, rd_req, ctrl_match, cell_frm, cell_valid;
    logic [3:0] cell_nib;
    logic [7:0] cell_byte [0:52]; // bytes captured by the sink
    int cell_count, errors, check_count, cells;
    control_cell_reply_generator #(.REVISION(REV)) dut (.clk(clk),
        .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .first_argument_byte(first_argument_byte),
        .second_argument_byte(second_argument_byte), .rd_done(rd_done),
        .rd_data(rd_data), .phy_interrupt_in(phy_interrupt_in),
        .hdr_vci_low(hdr_vci_low), .cmd_ready(cmd_ready), .rd_req(rd_req),
        .rd_addr(rd_addr), .ctrl_addr(ctrl_addr), .ctrl_match(ctrl_match),
        .cell_frm(cell_frm), .cell_valid(cell_valid), .cell_nib(cell_nib));
    cell_sink sink (.clk(clk), .sys_rst(sys_rst), .cell_frm(cell_frm),
        .cell_valid(cell_valid), .cell_nib(cell_nib),
        .cell_byte(cell_byte), .cell_count(cell_count));
    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // a hang counts as a mismatch and ends the run
    task hang(input string what);
        errors++;
        $display("CHECK FAILED %s expected done seen timeout", what);
        finish_test();
    endtask
    // command held one cycle, only once ready is seen high
    task send_cmd(input logic [7:0] c, input logic [7:0] a,
                  input logic [7:0] b);
        int k;
        for (k = 0; k < 300 && cmd_ready !== 1'b1; k++)
            @(negedge clk);
        if (k == 300)
            hang("cmd_ready");
        cmd_valid = 1'b1;
        cmd_byte = c;
        first_argument_byte = a;
        second_argument_byte = b;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask
    // one more cell within a bounded time, then every byte compared
    task check_cell(input logic [7:0] c, input logic [7:0] d1,
                    input logic [7:0] d2);
        int k;
        logic [7:0] e;
        cells++;
        for (k = 0; k < 400 && cell_count != cells; k++)
            @(negedge clk);
        if (k == 400)
            hang("cell");
        for (k = 0; k < 53; k++)
        begin
            e = (k == 2) ? 8'h02 : (k == 5) ? c : (k == 6) ? d1 :
                (k == 7) ? d2 : 8'h00;
            chk("cell byte", e, cell_byte[k]);
        end
    endtask
    task test_status;
        send_cmd(8'h05, 8'h33, 8'hCC);
        chk("cmd_ready busy", 8'h00, {7'h00, cmd_ready});
        check_cell(8'h05, 8'h00, REV);
        $display("status test done");
    endtask
    task test_read;
        int k;
        send_cmd(8'h03, 8'hA5, 8'h77);
        for (k = 0; k < 50 && rd_req !== 1'b1; k++)
            @(negedge clk);
        if (k == 50)
            hang("rd_req");
        chk("rd_addr", 8'hA5, rd_addr);
        rd_done = 1'b1;
        rd_data = 8'h3C;
        @(negedge clk);
        rd_done = 1'b0;
        rd_data = 8'hC3; // read data no longer held
        chk("rd_req low", 8'h00, {7'h00, rd_req});
        check_cell(8'h03, 8'hA5, 8'h3C);
        $display("read test done");
    endtask
    task test_interrupt;
        phy_interrupt_in = 1'b1;
        check_cell(8'h00, 8'h80, REV);
        send_cmd(8'h05, 8'h00, 8'h00);
        check_cell(8'h05, 8'h80, REV);
        phy_interrupt_in = 1'b0;
        $display("interrupt test done");
    endtask
    task test_addr;
        hdr_vci_low = 8'h1F;
        repeat (2) @(negedge clk);
        chk("ctrl_match old", 8'h01, {7'h00, ctrl_match});
        send_cmd(8'h06, 8'h47, 8'hFF);
        repeat (150) @(negedge clk);
        chk("cell count", 8'(cells), 8'(cell_count));
        chk("ctrl_addr", 8'h47, ctrl_addr);
        chk("ctrl_match old", 8'h00, {7'h00, ctrl_match});
        hdr_vci_low = 8'h47;
        repeat (2) @(negedge clk);
        chk("ctrl_match new", 8'h01, {7'h00, ctrl_match});
        $display("address change test done");
    endtask
    initial
    begin
        errors = 0;
        check_count = 0;
        cells = 0;
        sys_rst = 1'b1;
        {cmd_valid, rd_done, phy_interrupt_in} = 3'h0;
        {cmd_byte, first_argument_byte, second_argument_byte} = 24'h0;
        rd_data = 8'h00;
        hdr_vci_low = 8'h00;
        repeat (8) @(negedge clk);
        chk("ctrl_addr reset", 8'h1F, ctrl_addr);
        sys_rst = 1'b0;
        test_status();
        test_read();
        test_interrupt();
        test_addr();
        finish_test();
    end
endmodule
`default_nettype wire
